// >>> hdl/image_resize_csc.sv
// resize table config, two-tap interpolator and yuv to rgb converter
`timescale 1ns/1ps
`default_nettype none
`include "image_resize_csc_regs.svh"
// Function
// - 16-bit destination stride, upper bits read zero
// - horizontal table end index in bits 20:16
// - vertical table end index in bits 4:0
// - five 12-bit coefficients, scaled by 1024
// - rgb from offset-corrected luma and chroma
// - chroma offset 23:16, luma offset 7:0
// - start bit clears table, restarts loading
// - 10-bit weight in bits 11:2, /512
// - advance flag consumes one new source sample
// - output flag emits current interpolated sample
// - output weight*first plus (1-weight)*second
// - vertical table mirrors horizontal on lines
module image_resize_csc (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic pix_valid,
  input wire logic vert_sel,
  input wire logic [7:0] pix_in,
  output logic pix_take,
  output logic [7:0] pix_out,
  output logic pix_out_valid,
  input wire logic csc_valid,
  input wire logic [7:0] y_in,
  input wire logic [7:0] cb_in,
  input wire logic [7:0] cr_in,
  output logic [7:0] red,
  output logic [7:0] green,
  output logic [7:0] blue,
  output logic rgb_valid
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] stride;
    logic [4:0] hend;
    logic [4:0] vend;
    logic [11:0] c0;
    logic [11:0] c1;
    logic [11:0] c2;
    logic [11:0] c3;
    logic [11:0] c4;
    logic [7:0] chroma;
    logic [7:0] luma;
    logic [4:0] hwptr;
    logic [4:0] vwptr;
    logic [31:0] rdata;
    image_resize_csc_pkg::interp_state_t fsm;
    logic vsel;
    logic [4:0] idx;
    logic primed;
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] pout;
    logic pvalid;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic rgbv;
  } core_state_t;
  core_state_t st_reg;
  core_state_t st_next;

  table_mem_if h_if ();
  table_mem_if v_if ();

  resize_table_mem u_htab (.clk(clk), .srst(srst), .ce(ce), .port_m(h_if));
  resize_table_mem u_vtab (.clk(clk), .srst(srst), .ce(ce), .port_m(v_if));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] sat8(input logic signed [23:0] v);
    if (v < 24'sd0) begin
      sat8 = 8'h00;
    end else if (v > 24'sd255) begin
      sat8 = 8'hFF;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  logic wr_h;
  logic wr_v;
  logic [31:0] rd_mux;
  image_resize_csc_pkg::table_entry_t cur;
  logic [4:0] cur_end;
  logic signed [8:0] yd;
  logic signed [8:0] cbd;
  logic signed [8:0] crd;
  logic signed [23:0] ry;
  logic signed [23:0] rsum;
  logic signed [23:0] gsum;
  logic signed [23:0] bsum;
  logic [18:0] mix;

  assign wr_h = wr && (addr == `OFS_HORIZ_TABLE_PORT);
  assign wr_v = wr && (addr == `OFS_VERT_TABLE_PORT);

  // ------------------------------------------------------------
  // table write side
  // ------------------------------------------------------------
  // start clears table
  assign h_if.clear = wr_h && wdata[`START_BIT];
  assign v_if.clear = wr_v && wdata[`START_BIT];
  assign h_if.we = wr_h && !wdata[`START_BIT];
  assign v_if.we = wr_v && !wdata[`START_BIT];
  assign h_if.waddr = st_reg.hwptr;
  assign v_if.waddr = st_reg.vwptr;
  assign h_if.wdata = '{weight: wdata[`WEIGHT_MSB:`WEIGHT_LSB],
    advance: wdata[`ADVANCE_BIT], emit: wdata[`OUTPUT_BIT]};
  assign v_if.wdata = h_if.wdata;
  // read ahead so the entry matches the step index
  assign h_if.raddr = st_next.idx;
  assign v_if.raddr = st_next.idx;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = `ZERO_WORD;
    case (addr)
      `OFS_DEST_LINE_STRIDE: rd_mux[`STRIDE_MSB:0] = st_reg.stride;
      `OFS_TABLE_END_INDEX: begin
        rd_mux[`HEND_MSB:`HEND_LSB] = st_reg.hend;
        rd_mux[`VEND_MSB:`VEND_LSB] = st_reg.vend;
      end
      `OFS_CSC_COEF_ZERO: rd_mux[`COEF_MSB:0] = st_reg.c0;
      `OFS_CSC_COEF_ONE: rd_mux[`COEF_MSB:0] = st_reg.c1;
      `OFS_CSC_COEF_TWO: rd_mux[`COEF_MSB:0] = st_reg.c2;
      `OFS_CSC_COEF_THREE: rd_mux[`COEF_MSB:0] = st_reg.c3;
      `OFS_CSC_COEF_FOUR: rd_mux[`COEF_MSB:0] = st_reg.c4;
      `OFS_CSC_OFFSETS: begin
        rd_mux[`CHROMA_MSB:`CHROMA_LSB] = st_reg.chroma;
        rd_mux[`LUMA_MSB:`LUMA_LSB] = st_reg.luma;
      end
      `OFS_ENTRY_READBACK: begin
        rd_mux[14:10] = st_reg.idx;
        rd_mux[9:5] = st_reg.hwptr;
        rd_mux[4:0] = st_reg.vwptr;
      end
      default: rd_mux = `ZERO_WORD;
    endcase
  end

  // ------------------------------------------------------------
  // interpolator and converter datapath
  // ------------------------------------------------------------
  assign cur = st_reg.vsel ? v_if.rdata : h_if.rdata;
  assign cur_end = st_reg.vsel ? st_reg.vend : st_reg.hend;
  assign mix = 19'(cur.weight) * 19'(st_reg.first)
    + (19'd512 - 19'(cur.weight)) * 19'(st_reg.second);

  assign yd = $signed({1'b0, y_in}) - $signed({1'b0, st_reg.luma});
  assign cbd = $signed({1'b0, cb_in}) - $signed({1'b0, st_reg.chroma});
  assign crd = $signed({1'b0, cr_in}) - $signed({1'b0, st_reg.chroma});
  assign ry = 24'(yd) * 24'($signed({1'b0, st_reg.c0}));
  assign rsum = (ry + 24'(crd) * 24'($signed({1'b0, st_reg.c1})))
    >>> 10;
  assign gsum = (ry - 24'(cbd) * 24'($signed({1'b0, st_reg.c2}))
    - 24'(crd) * 24'($signed({1'b0, st_reg.c3}))) >>> 10;
  assign bsum = (ry + 24'(cbd) * 24'($signed({1'b0, st_reg.c4})))
    >>> 10;

  always_comb begin
    st_next = st_reg;
    st_next.pvalid = 1'b0;
    st_next.rgbv = 1'b0;
    st_next.rdata = rd ? rd_mux : `ZERO_WORD;
    if (wr) begin
      case (addr)
        `OFS_DEST_LINE_STRIDE: st_next.stride = wdata[`STRIDE_MSB:0];
        `OFS_TABLE_END_INDEX: begin
          st_next.hend = wdata[`HEND_MSB:`HEND_LSB];
          st_next.vend = wdata[`VEND_MSB:`VEND_LSB];
        end
        `OFS_CSC_COEF_ZERO: st_next.c0 = wdata[`COEF_MSB:0];
        `OFS_CSC_COEF_ONE: st_next.c1 = wdata[`COEF_MSB:0];
        `OFS_CSC_COEF_TWO: st_next.c2 = wdata[`COEF_MSB:0];
        `OFS_CSC_COEF_THREE: st_next.c3 = wdata[`COEF_MSB:0];
        `OFS_CSC_COEF_FOUR: st_next.c4 = wdata[`COEF_MSB:0];
        `OFS_CSC_OFFSETS: begin
          st_next.chroma = wdata[`CHROMA_MSB:`CHROMA_LSB];
          st_next.luma = wdata[`LUMA_MSB:`LUMA_LSB];
        end
        `OFS_HORIZ_TABLE_PORT: begin
          st_next.hwptr = wdata[`START_BIT] ? 5'h00 : st_reg.hwptr + 5'h01;
        end
        `OFS_VERT_TABLE_PORT: begin
          st_next.vwptr = wdata[`START_BIT] ? 5'h00 : st_reg.vwptr + 5'h01;
        end
        default: begin
        end
      endcase
    end
    // restarting either table also restarts the walk
    if (h_if.clear || v_if.clear) begin
      st_next.fsm = image_resize_csc_pkg::ST_IDLE;
      st_next.idx = 5'h00;
      st_next.primed = 1'b0;
    end else begin
      case (st_reg.fsm)
        image_resize_csc_pkg::ST_IDLE: begin
          if (pix_valid) begin
            st_next.vsel = vert_sel;
            st_next.idx = 5'h00;
            st_next.first = pix_in;
            st_next.primed = 1'b0;
            st_next.fsm = image_resize_csc_pkg::ST_RUN;
          end
        end
        image_resize_csc_pkg::ST_RUN: begin
          if (!st_reg.primed) begin
            if (pix_valid) begin
              st_next.second = pix_in;
              st_next.primed = 1'b1;
            end
          end else if (!cur.advance || pix_valid) begin
            if (cur.emit) begin
              st_next.pout = 8'(mix >> 9);
              st_next.pvalid = 1'b1;
            end
            if (cur.advance) begin
              st_next.first = st_reg.second;
              st_next.second = pix_in;
            end
            st_next.idx = (st_reg.idx == cur_end) ? 5'h00
              : st_reg.idx + 5'h01;
          end
        end
        default: st_next.fsm = image_resize_csc_pkg::ST_IDLE;
      endcase
    end
    if (csc_valid) begin
      st_next.r = sat8(rsum);
      st_next.g = sat8(gsum);
      st_next.b = sat8(bsum);
      st_next.rgbv = 1'b1;
    end
  end

  assign pix_take = pix_valid && ce && !h_if.clear && !v_if.clear &&
    ((st_reg.fsm == image_resize_csc_pkg::ST_IDLE) ||
     (st_reg.fsm == image_resize_csc_pkg::ST_RUN &&
      (!st_reg.primed || cur.advance)));

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.fsm <= image_resize_csc_pkg::ST_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign pix_out = st_reg.pout;
  assign pix_out_valid = st_reg.pvalid;
  assign red = st_reg.r;
  assign green = st_reg.g;
  assign blue = st_reg.b;
  assign rgb_valid = st_reg.rgbv;
endmodule
`default_nettype wire

// >>> hdl/image_resize_csc_regs.svh
// register offsets, field positions and table depth of the resize/csc block
`ifndef IMAGE_RESIZE_CSC_REGS_SVH
`define IMAGE_RESIZE_CSC_REGS_SVH
`define OFS_DEST_LINE_STRIDE 8'h00
`define OFS_TABLE_END_INDEX 8'h04
`define OFS_CSC_COEF_ZERO 8'h08
`define OFS_CSC_COEF_ONE 8'h0C
`define OFS_CSC_COEF_TWO 8'h10
`define OFS_CSC_COEF_THREE 8'h14
`define OFS_CSC_COEF_FOUR 8'h18
`define OFS_HORIZ_TABLE_PORT 8'h1C
`define OFS_VERT_TABLE_PORT 8'h20
`define OFS_CSC_OFFSETS 8'h24
`define OFS_ENTRY_READBACK 8'h28
`define STRIDE_MSB 15
`define HEND_MSB 20
`define HEND_LSB 16
`define VEND_MSB 4
`define VEND_LSB 0
`define COEF_MSB 11
`define START_BIT 12
`define WEIGHT_MSB 11
`define WEIGHT_LSB 2
`define ADVANCE_BIT 1
`define OUTPUT_BIT 0
`define CHROMA_MSB 23
`define CHROMA_LSB 16
`define LUMA_MSB 7
`define LUMA_LSB 0
`define TABLE_DEPTH 32
`define ZERO_WORD 32'h00000000
`endif

// >>> hdl/image_resize_csc_pkg.sv
// types shared by the resize/csc block
package image_resize_csc_pkg;
  typedef struct packed {
    logic [9:0] weight;
    logic advance;
    logic emit;
  } table_entry_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } interp_state_t;
endpackage

// >>> hdl/table_mem_if.sv
// interface between the controller and its coefficient table memory
`timescale 1ns/1ps
`default_nettype none
interface table_mem_if;
  logic we;
  logic clear;
  logic [4:0] waddr;
  image_resize_csc_pkg::table_entry_t wdata;
  logic [4:0] raddr;
  image_resize_csc_pkg::table_entry_t rdata;
  modport ctrl (output we, output clear, output waddr, output wdata,
    output raddr, input rdata);
  modport mem (input we, input clear, input waddr, input wdata,
    input raddr, output rdata);
endinterface
`default_nettype wire

// >>> hdl/resize_table_mem.sv
// one 32-entry resize coefficient table with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "image_resize_csc_regs.svh"
module resize_table_mem (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  table_mem_if.mem port_m
);
  typedef struct packed {
    image_resize_csc_pkg::table_entry_t [`TABLE_DEPTH-1:0] ent;
    image_resize_csc_pkg::table_entry_t rd;
  } mem_state_t;
  mem_state_t st_reg;
  mem_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (port_m.clear) begin
      st_next.ent = '0;
    end else if (port_m.we) begin
      st_next.ent[port_m.waddr] = port_m.wdata;
    end
    st_next.rd = st_reg.ent[port_m.raddr];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign port_m.rdata = st_reg.rd;
endmodule
`default_nettype wire

// >>> verification/image_resize_csc_checker.sv
// port assertions for the resize/csc block
`timescale 1ns/1ps
`default_nettype none
`include "image_resize_csc_regs.svh"
module image_resize_csc_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic pix_valid,
  input wire logic vert_sel,
  input wire logic [7:0] pix_in,
  input wire logic pix_take,
  input wire logic [7:0] pix_out,
  input wire logic pix_out_valid,
  input wire logic csc_valid,
  input wire logic [7:0] y_in,
  input wire logic [7:0] cb_in,
  input wire logic [7:0] cr_in,
  input wire logic [7:0] red,
  input wire logic [7:0] green,
  input wire logic [7:0] blue,
  input wire logic rgb_valid
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  stride_rsvd_a: assert property ($past(rd) &&
    $past(addr) == `OFS_DEST_LINE_STRIDE |-> rdata[31:16] == 16'h0000)
    else $error("stride upper bits set");
  hend_rsvd_a: assert property ($past(rd) &&
    $past(addr) == `OFS_TABLE_END_INDEX |-> rdata[31:21] == 11'h000)
    else $error("end index top bits set");
  vend_rsvd_a: assert property ($past(rd) &&
    $past(addr) == `OFS_TABLE_END_INDEX |-> rdata[15:5] == 11'h000)
    else $error("end index middle bits set");
  coef_rsvd_a: assert property ($past(rd) &&
    $past(addr) inside {[8'h08:8'h18]} |-> rdata[31:12] == 20'h00000)
    else $error("coefficient upper bits set");
  table_wo_a: assert property ($past(rd) &&
    $past(addr) inside {`OFS_HORIZ_TABLE_PORT, `OFS_VERT_TABLE_PORT}
    |-> rdata == 32'h00000000)
    else $error("table port read not zero");
  offs_rsvd_a: assert property ($past(rd) &&
    $past(addr) == `OFS_CSC_OFFSETS |->
    rdata[31:24] == 8'h00 && rdata[15:8] == 8'h00)
    else $error("offset reserved bits set");
  rgb_pulse_a: assert property ($past(ce) |->
    rgb_valid == $past(csc_valid))
    else $error("rgb valid not one cycle after input");
  take_valid_a: assert property (pix_take |-> pix_valid)
    else $error("sample taken without valid");
endmodule
bind image_resize_csc image_resize_csc_checker u_image_resize_csc_checker (
  .clk, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata, .pix_valid,
  .vert_sel, .pix_in, .pix_take, .pix_out, .pix_out_valid, .csc_valid,
  .y_in, .cb_in, .cr_in, .red, .green, .blue, .rgb_valid);
`default_nettype wire

// >>> verification/image_resize_csc_tb_top.sv
// self-checking bench for the resize/csc block
`timescale 1ns/1ps
`default_nettype none
`include "image_resize_csc_regs.svh"
module image_resize_csc_tb_top;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
  logic [7:0] addr = 8'h00, pix_in = 8'h00;
  logic [7:0] y_in = 8'h00, cb_in = 8'h00, cr_in = 8'h00;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic wr = 1'b0, rd = 1'b0, pix_valid = 1'b0, vert_sel = 1'b0;
  logic csc_valid = 1'b0, pix_take, pix_out_valid, rgb_valid;
  logic [7:0] pix_out, red, green, blue;
  int err_count = 0, n_checks = 0, cyc = 0, wt = 0, j = 0;
  int unsigned seed = 72243;
  int hist[$];
  int co[5];
  int lo, ch, ev;
  int wts[4], em[4];
  int s = 0, nent = 1, nexp = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h24};
  logic [31:0] rm [8] = '{32'h0000FFFF, 32'h001F001F, 32'h00000FFF,
    32'h00000FFF, 32'h00000FFF, 32'h00000FFF, 32'h00000FFF, 32'h00FF00FF};
  always #25 clk = ~clk;
  image_resize_csc u_image_resize_csc (.clk, .srst, .ce, .addr, .wdata,
    .wr, .rd, .rdata, .pix_valid, .vert_sel, .pix_in, .pix_take, .pix_out,
    .pix_out_valid, .csc_valid, .y_in, .cb_in, .cr_in, .red, .green,
    .blue, .rgb_valid);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] sat(input int v);
    return v < 0 ? 32'h0 : (v > 255 ? 32'hFF : v);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic csc_run();
    int y, u, v, l;
    y = rnd() & 255;
    u = rnd() & 255;
    v = rnd() & 255;
    l = co[0] * (y - lo);
    @(posedge clk);
    y_in <= y[7:0];
    cb_in <= u[7:0];
    cr_in <= v[7:0];
    csc_valid <= 1'b1;
    @(posedge clk);
    csc_valid <= 1'b0;
    #1 chk(rgb_valid, 1);
    chk(red, sat((l + co[1] * (v - ch)) >>> 10));
    chk(green, sat((l - co[2] * (u - ch) - co[3] * (v - ch)) >>> 10));
    chk(blue, sat((l + co[4] * (u - ch)) >>> 10));
  endtask
  task automatic interp_run(input logic vs, input logic [7:0] pa, int ne);
    nent = ne;
    nexp = 0;
    wr_reg(pa, 32'h00000001);
    wr_reg(pa, 32'h00001000);
    // a 1:1 or down-scale table, all advance
    for (int k = 0; k < ne; k++) begin
      wts[k] = rnd() % 513;
      em[k] = (k == 0) ? 1 : (rnd() & 1);
      wr_reg(pa, {wts[k][9:0], 1'b1, em[k][0]});
    end
    for (int k = 0; k < 28; k++) nexp += em[k % ne];
    rd_chk(pa, 32'h0);
    hist.delete();
    j = 0;
    s = 0;
    @(posedge clk);
    vert_sel <= vs;
    pix_valid <= 1'b1;
    repeat (30) @(posedge clk);
    pix_valid <= 1'b0;
    repeat (4) @(posedge clk);
    chk(j, nexp);
    $display("interpolation run done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      stop_test();
    end
    if (pix_out_valid) begin
      while (em[s % nent] == 0) s++;
      wt = wts[s % nent];
      ev = (wt * hist[s] + (512 - wt) * hist[s + 1]) >> 9;
      chk(pix_out, ev);
      s++;
      j++;
    end
    if (pix_take) begin
      hist.push_back(pix_in);
      pix_in <= 8'(rnd());
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++) rd_chk(8'(i * 4), 32'h0);
    repeat (2) begin
      for (int i = 0; i < 8; i++) begin
        rv = rnd();
        wr_reg(ra[i], rv);
        rd_chk(ra[i], rv & rm[i]);
      end
    end
    wr_reg(8'hFC, 32'hFFFFFFFF);
    rd_chk(8'hFC, 32'h0);
    wr_reg(`OFS_DEST_LINE_STRIDE, 32'h00001234);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`OFS_DEST_LINE_STRIDE, 32'h0000ABCD);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(`OFS_DEST_LINE_STRIDE, 32'h00001234);
    $display("register test done");
    repeat (20) begin
      for (int i = 0; i < 5; i++) begin
        co[i] = (rnd() & 3) << 10;
        wr_reg(8'(8 + i * 4), co[i]);
      end
      lo = rnd() & 255;
      ch = rnd() & 255;
      wr_reg(`OFS_CSC_OFFSETS, {8'h00, ch[7:0], 8'h00, lo[7:0]});
      repeat (4) csc_run();
    end
    $display("conversion test done");
    wr_reg(`OFS_TABLE_END_INDEX, 32'h00010002);
    interp_run(1'b0, `OFS_HORIZ_TABLE_PORT, 2);
    interp_run(1'b1, `OFS_VERT_TABLE_PORT, 3);
    stop_test();
  end
endmodule
`default_nettype wire
